//--- logic/mftl_pkg.sv
package mftl_pkg;

    // clock and times
    localparam int unsigned CLK_KHZ        = 100_000;
    localparam int unsigned UD_FAST_MS     = 10;
    localparam int unsigned UD_SLOW_MS     = 100;
    localparam int unsigned CNT_MIN_MS     = 2;
    localparam int unsigned UD_FAST_CYC    = UD_FAST_MS * CLK_KHZ;
    localparam int unsigned UD_SLOW_CYC    = UD_SLOW_MS * CLK_KHZ;
    localparam int unsigned CNT_MIN_CYC    = CNT_MIN_MS * CLK_KHZ;
    localparam int unsigned TMR_W          = 24;
    localparam logic [4:0]  UD_FAST_STEPS  = 5'h14;

    // widths
    localparam int unsigned NUM_TERM       = 8;
    localparam int unsigned NUM_OUT        = 4;
    localparam int unsigned FREQ_W         = 16;
    localparam int unsigned CNT_W          = 16;
    localparam int unsigned CODE_W         = 6;
    localparam logic [15:0] CNT_MAX        = 16'hffff;
    localparam logic [15:0] FREQ_STEP      = 16'h0001;

    // frequency-mode and source values
    localparam logic [3:0]  MODE_EXT_MAX   = 4'h2;
    localparam logic [3:0]  MODE_FOUR_SPD  = 4'h1;
    localparam logic [3:0]  MODE_MULTI     = 4'h2;
    localparam logic [1:0]  SRC_PANEL      = 2'h0;

    // input terminal function codes
    localparam logic [5:0]  IN_HIGH        = 6'h11;
    localparam logic [5:0]  IN_MIDDLE      = 6'h12;
    localparam logic [5:0]  IN_LOW         = 6'h13;
    localparam logic [5:0]  IN_MULTI1      = 6'h14;
    localparam logic [5:0]  IN_RAMP1       = 6'h17;
    localparam logic [5:0]  IN_RAMP2       = 6'h18;
    localparam logic [5:0]  IN_UP          = 6'h19;
    localparam logic [5:0]  IN_DOWN        = 6'h1a;
    localparam logic [5:0]  IN_CNT_PULSE   = 6'h1b;
    localparam logic [5:0]  IN_CNT_RESET   = 6'h1c;

    // output function codes
    localparam logic [5:0]  OUT_CODE_MAX   = 6'h20;
    localparam logic [5:0]  OUT1_DEFAULT   = 6'h01;
    localparam logic [5:0]  OUT2_DEFAULT   = 6'h05;
    localparam logic [5:0]  OUT3_DEFAULT   = 6'h02;
    localparam logic [5:0]  OUT4_DEFAULT   = 6'h00;

    typedef enum logic [1:0] {
        SPD_MAIN,
        SPD_LOW,
        SPD_MIDDLE,
        SPD_HIGH
    } mftl_speed_t;

    typedef struct packed {
        logic [15:0] main_frequency_setting;
        logic [15:0] preset_frequency_two;
        logic [15:0] preset_frequency_three;
        logic [15:0] preset_frequency_four;
        logic [15:0] max_frequency;
        logic [15:0] min_frequency;
        logic [15:0] lower_limit;
    } mftl_freq_cfg_t;

    typedef struct packed {
        logic running;
        logic run_command;
        logic fault;
        logic dc_braking;
        logic accelerating;
        logic decelerating;
        logic drive_overload;
        logic motor_overload;
        logic over_torque;
        logic low_voltage;
        logic step_done;
        logic cycle_done;
        logic timer_one_reach;
        logic timer_two_reach;
        logic loop_open;
        logic drawing_done;
        logic fan_active;
        logic relay_pulled;
        logic brake_resistor;
    } mftl_status_t;

    typedef struct packed {
        logic [15:0] output_frequency;
        logic [15:0] start_frequency;
        logic [15:0] uniform_frequency_one;
        logic [15:0] uniform_frequency_two;
        logic [15:0] feedback;
        logic [15:0] feedback_upper_limit;
        logic [15:0] feedback_lower_limit;
    } mftl_meas_t;

endpackage

//--- logic/mftl_sync.sv
`timescale 1ns/10ps
module mftl_sync #(
    parameter int unsigned WIDTH = 8
) (
    input  wire logic             i_core_clk,
    input  wire logic             i_rst_n,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            meta_reg <= '0;
            o_sync   <= '0;
        end else begin
            meta_reg <= i_async;
            o_sync   <= meta_reg;
        end
    end

endmodule

//--- logic/mftl_terminal_logic.sv
`timescale 1ns/10ps
// How it works
// - ramp selection only applies in frequency modes 0, 1 or 2.
// - input code 23 is ramp bit one, code 24 ramp bit two.
// - ramp bits decode to ramp 1..4 as a two-bit number.
// - no speed input uses main setting; low, middle, high use presets 2, 3, 4.
// - high speed beats middle, middle beats low.
// - speed terminals apply only in frequency mode 1.
// - UP and DOWN act only when frequency source is the panel.
// - UP alone raises, DOWN alone lowers, both together do nothing.
// - adjustment stops at maximum, and at minimum or lower limit.
// - held UP or DOWN steps fast first, then at a slow steady rate.
// - panel arrow edits act only on confirm, then written to main setting.
// - multi-speed inputs apply only in frequency mode 2.
// - counter stops at its target and asserts the output until reset.
// - counter saturates at 65535 and never wraps.
// - four output function codes 0..32, defaults 01, 05, 02, 00.
// - code 00 idle; 01 run, 02 fault, 03 zero speed, 04 dc brake, 05 reach.
// - codes 06, 07 uniform frequency reach; 08 ramp-up; 09 ramp-down.
// - codes 10..13 overloads, torque, low volt; 30..32 fan, relay, brake.
// - codes 14 and 15 follow the step end and cycle end status levels.
// - code 16 count equals target; code 17 count at least intermediate.
// - codes 18, 19 timer reach; code 20 current loop open.
// - code 27 drawing done until stop; 28 feedback low; 29 feedback high.
// - input code 27 is the counter pulse input.
// - input code 28 clears the count, then counting restarts.
module mftl_terminal_logic #(
    parameter int unsigned UD_FAST_CYC = mftl_pkg::UD_FAST_CYC,
    parameter int unsigned UD_SLOW_CYC = mftl_pkg::UD_SLOW_CYC,
    parameter int unsigned CNT_MIN_CYC = mftl_pkg::CNT_MIN_CYC
) (
    // clock and reset
    input  wire logic                  i_core_clk,
    input  wire logic                  i_rst_n,
    // input terminals and their function codes
    input  wire logic [7:0]            i_terminal,
    input  wire logic [7:0][5:0]       i_input_function,
    // mode settings
    input  wire logic [3:0]            i_frequency_mode_setting,
    input  wire logic [1:0]            i_frequency_source_select,
    input  mftl_pkg::mftl_freq_cfg_t   i_freq_cfg,
    // panel keys, one-cycle pulses
    input  wire logic                  i_key_up,
    input  wire logic                  i_key_down,
    input  wire logic                  i_key_enter,
    // counter settings
    input  wire logic [15:0]           i_count_target,
    input  wire logic [15:0]           i_intermediate_count_target,
    // output function code load
    input  wire logic [3:0]            i_output_function_wr,
    input  wire logic [5:0]            i_output_function_data,
    // drive status
    input  mftl_pkg::mftl_status_t     i_status,
    input  mftl_pkg::mftl_meas_t       i_meas,
    // decoded selections
    output logic [1:0]                 o_ramp_select,
    output mftl_pkg::mftl_speed_t      o_speed_select,
    output logic [2:0]                 o_multi_speed_select,
    output logic [15:0]                o_frequency_command,
    output logic                       o_main_write,
    output logic [15:0]                o_main_write_value,
    // counter
    output logic [15:0]                o_count,
    output logic                       o_count_reached,
    // output contacts
    output logic [3:0]                 o_contact,
    output logic [3:0][5:0]            o_output_function
);

    logic [7:0]  term_sync;
    logic        ramp1_on;
    logic        ramp2_on;
    logic        high_on;
    logic        middle_on;
    logic        low_on;
    logic [2:0]  multi_on;
    logic        up_on;
    logic        down_on;
    logic        cnt_pulse_on;
    logic        cnt_reset_on;
    logic        ud_mode;
    logic        move;
    logic        move_up;
    logic        move_down;
    logic        step_now;
    logic [15:0] lo_limit;
    logic [15:0] base_freq;
    logic [15:0] edit_base;
    logic [23:0] interval;
    logic        move_d_reg;
    logic [23:0] hold_cnt_reg;
    logic [4:0]  nsteps_reg;
    logic [15:0] ud_freq_reg;
    logic        edit_reg;
    logic [15:0] pend_reg;
    logic        filt_reg;
    logic [23:0] filt_cnt_reg;
    logic        cnt_rise;
    logic        drawing_reg;
    logic [32:0] cond;

    mftl_sync #(
        .WIDTH (mftl_pkg::NUM_TERM)
    ) u_sync (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_async    (i_terminal),
        .o_sync     (term_sync)
    );

    // true when any active terminal carries the given function code
    function automatic logic term_has(input logic [7:0] act,
                                      input logic [7:0][5:0] fn,
                                      input logic [5:0] code);
        logic hit;
        hit = 1'b0;
        for (int t = 0; t < mftl_pkg::NUM_TERM; t++) begin
            hit = hit | (act[t] & (fn[t] == code));
        end
        return hit;
    endfunction

    always_comb begin
        ramp1_on     = term_has(term_sync, i_input_function, mftl_pkg::IN_RAMP1);
        ramp2_on     = term_has(term_sync, i_input_function, mftl_pkg::IN_RAMP2);
        high_on      = term_has(term_sync, i_input_function, mftl_pkg::IN_HIGH);
        middle_on    = term_has(term_sync, i_input_function, mftl_pkg::IN_MIDDLE);
        low_on       = term_has(term_sync, i_input_function, mftl_pkg::IN_LOW);
        up_on        = term_has(term_sync, i_input_function, mftl_pkg::IN_UP);
        down_on      = term_has(term_sync, i_input_function, mftl_pkg::IN_DOWN);
        cnt_pulse_on = term_has(term_sync, i_input_function, mftl_pkg::IN_CNT_PULSE);
        cnt_reset_on = term_has(term_sync, i_input_function, mftl_pkg::IN_CNT_RESET);
        for (int m = 0; m < 3; m++) begin
            multi_on[m] = term_has(term_sync, i_input_function,
                                   mftl_pkg::IN_MULTI1 + 6'(m));
        end
    end

    // ramp selection
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n || i_frequency_mode_setting > mftl_pkg::MODE_EXT_MAX) begin
            o_ramp_select <= 2'h0;
        end else begin
            o_ramp_select <= {ramp2_on, ramp1_on};
        end
    end

    // multi-speed selection
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n || i_frequency_mode_setting != mftl_pkg::MODE_MULTI) begin
            o_multi_speed_select <= 3'h0;
        end else begin
            o_multi_speed_select <= multi_on;
        end
    end

    // up/down adjustment
    assign ud_mode   = (i_frequency_source_select == mftl_pkg::SRC_PANEL);
    assign move_up   = ud_mode & up_on & ~down_on;
    assign move_down = ud_mode & down_on & ~up_on;
    assign move      = move_up | move_down;
    assign interval  = (nsteps_reg < mftl_pkg::UD_FAST_STEPS) ?
                       24'(UD_FAST_CYC) : 24'(UD_SLOW_CYC);
    assign step_now  = move & (~move_d_reg | (hold_cnt_reg == interval - 24'h1));
    assign lo_limit  = (i_freq_cfg.min_frequency > i_freq_cfg.lower_limit) ?
                       i_freq_cfg.min_frequency : i_freq_cfg.lower_limit;

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            move_d_reg   <= 1'b0;
            hold_cnt_reg <= 24'h0;
            nsteps_reg   <= 5'h0;
        end else begin
            move_d_reg <= move;
            if (!move || step_now) begin
                hold_cnt_reg <= 24'h0;
            end else begin
                hold_cnt_reg <= hold_cnt_reg + 24'h1;
            end
            if (!move) begin
                nsteps_reg <= 5'h0;
            end else if (step_now && nsteps_reg < mftl_pkg::UD_FAST_STEPS) begin
                nsteps_reg <= nsteps_reg + 5'h1;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            ud_freq_reg <= 16'h0;
        end else if (!ud_mode) begin
            ud_freq_reg <= i_freq_cfg.main_frequency_setting;
        end else if (i_key_enter) begin
            ud_freq_reg <= pend_reg;
        end else if (step_now && move_up) begin
            if (ud_freq_reg >= i_freq_cfg.max_frequency) begin
                ud_freq_reg <= i_freq_cfg.max_frequency;
            end else begin
                ud_freq_reg <= ud_freq_reg + mftl_pkg::FREQ_STEP;
            end
        end else if (step_now && move_down) begin
            if (ud_freq_reg <= lo_limit) begin
                ud_freq_reg <= lo_limit;
            end else begin
                ud_freq_reg <= ud_freq_reg - mftl_pkg::FREQ_STEP;
            end
        end
    end

    // panel arrow edits stay pending until confirmed
    assign edit_base = edit_reg ? pend_reg : ud_freq_reg;

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            edit_reg <= 1'b0;
            pend_reg <= 16'h0;
        end else if (!ud_mode || i_key_enter) begin
            edit_reg <= 1'b0;
            pend_reg <= edit_reg ? pend_reg : ud_freq_reg;
        end else if (i_key_up && !i_key_down) begin
            edit_reg <= 1'b1;
            pend_reg <= (edit_base >= i_freq_cfg.max_frequency) ?
                        i_freq_cfg.max_frequency : edit_base + mftl_pkg::FREQ_STEP;
        end else if (i_key_down && !i_key_up) begin
            edit_reg <= 1'b1;
            pend_reg <= (edit_base <= lo_limit) ?
                        lo_limit : edit_base - mftl_pkg::FREQ_STEP;
        end else if (!edit_reg) begin
            pend_reg <= ud_freq_reg;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_main_write       <= 1'b0;
            o_main_write_value <= 16'h0;
        end else begin
            o_main_write <= ud_mode & i_key_enter;
            if (ud_mode && i_key_enter) begin
                o_main_write_value <= pend_reg;
            end
        end
    end

    // speed selection and frequency command
    assign base_freq = ud_mode ? ud_freq_reg : i_freq_cfg.main_frequency_setting;

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_speed_select      <= mftl_pkg::SPD_MAIN;
            o_frequency_command <= 16'h0;
        end else if (i_frequency_mode_setting != mftl_pkg::MODE_FOUR_SPD) begin
            o_speed_select      <= mftl_pkg::SPD_MAIN;
            o_frequency_command <= base_freq;
        end else if (high_on) begin
            o_speed_select      <= mftl_pkg::SPD_HIGH;
            o_frequency_command <= i_freq_cfg.preset_frequency_four;
        end else if (middle_on) begin
            o_speed_select      <= mftl_pkg::SPD_MIDDLE;
            o_frequency_command <= i_freq_cfg.preset_frequency_three;
        end else if (low_on) begin
            o_speed_select      <= mftl_pkg::SPD_LOW;
            o_frequency_command <= i_freq_cfg.preset_frequency_two;
        end else begin
            o_speed_select      <= mftl_pkg::SPD_MAIN;
            o_frequency_command <= base_freq;
        end
    end

    // counter pulse filter: level must stand for the least width
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            filt_reg     <= 1'b0;
            filt_cnt_reg <= 24'h0;
            cnt_rise     <= 1'b0;
        end else begin
            cnt_rise <= 1'b0;
            if (cnt_pulse_on == filt_reg) begin
                filt_cnt_reg <= 24'h0;
            end else if (filt_cnt_reg >= 24'(CNT_MIN_CYC) - 24'h1) begin
                filt_cnt_reg <= 24'h0;
                filt_reg     <= cnt_pulse_on;
                cnt_rise     <= cnt_pulse_on;
            end else begin
                filt_cnt_reg <= filt_cnt_reg + 24'h1;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_count         <= 16'h0;
            o_count_reached <= 1'b0;
        end else begin
            o_count_reached <= (o_count == i_count_target);
            if (cnt_reset_on) begin
                o_count <= 16'h0;
            end else if (cnt_rise && o_count != i_count_target
                         && o_count != mftl_pkg::CNT_MAX) begin
                o_count <= o_count + 16'h1;
            end
        end
    end

    // drawing reach latch, set wins over the clear on stop
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            drawing_reg <= 1'b0;
        end else if (i_status.drawing_done) begin
            drawing_reg <= 1'b1;
        end else if (!i_status.running) begin
            drawing_reg <= 1'b0;
        end
    end

    // status condition per output function code
    always_comb begin
        cond     = 33'h0;
        cond[1]  = i_status.running | i_status.run_command;
        cond[2]  = i_status.fault;
        cond[3]  = i_meas.output_frequency < i_meas.start_frequency;
        cond[4]  = i_status.dc_braking;
        cond[5]  = i_meas.output_frequency == o_frequency_command;
        cond[6]  = i_meas.output_frequency >= i_meas.uniform_frequency_one;
        cond[7]  = i_meas.output_frequency >= i_meas.uniform_frequency_two;
        cond[8]  = i_status.accelerating;
        cond[9]  = i_status.decelerating;
        cond[10] = i_status.drive_overload;
        cond[11] = i_status.motor_overload;
        cond[12] = i_status.over_torque;
        cond[13] = i_status.low_voltage;
        cond[14] = i_status.step_done;
        cond[15] = i_status.cycle_done;
        cond[16] = o_count == i_count_target;
        cond[17] = o_count >= i_intermediate_count_target;
        cond[18] = i_status.timer_one_reach;
        cond[19] = i_status.timer_two_reach;
        cond[20] = i_status.loop_open;
        cond[27] = drawing_reg;
        cond[28] = i_meas.feedback < i_meas.feedback_lower_limit;
        cond[29] = i_meas.feedback > i_meas.feedback_upper_limit;
        cond[30] = i_status.fan_active;
        cond[31] = i_status.relay_pulled;
        cond[32] = i_status.brake_resistor;
    end

    // output contacts
    for (genvar k = 0; k < mftl_pkg::NUM_OUT; k++) begin : g_out
        localparam logic [5:0] DEF = (k == 0) ? mftl_pkg::OUT1_DEFAULT :
                                     (k == 1) ? mftl_pkg::OUT2_DEFAULT :
                                     (k == 2) ? mftl_pkg::OUT3_DEFAULT :
                                                mftl_pkg::OUT4_DEFAULT;

        always_ff @(posedge i_core_clk) begin
            if (!i_rst_n) begin
                o_output_function[k] <= DEF;
            end else if (i_output_function_wr[k]
                         && i_output_function_data <= mftl_pkg::OUT_CODE_MAX) begin
                o_output_function[k] <= i_output_function_data;
            end
        end

        always_ff @(posedge i_core_clk) begin
            if (!i_rst_n) begin
                o_contact[k] <= 1'b0;
            end else begin
                o_contact[k] <= cond[o_output_function[k]];
            end
        end
    end

endmodule

//--- testbench/mftl_switch_bank.sv
`timescale 1ns/10ps
module mftl_switch_bank (
    // actuator side
    input  wire logic       i_core_clk,
    input  wire logic [7:0] i_close,
    // contact levels seen by the drive
    output logic      [7:0] o_level = 8'h00
);
    // contacts settle one clock after the actuator moves, so edges land on the rising clock edge
    always_ff @(posedge i_core_clk) begin
        o_level <= i_close;
    end
endmodule

//--- testbench/mftl_terminal_logic_monitor.sv
`timescale 1ns/10ps
module mftl_terminal_logic_monitor (
    // watched inputs
    input wire logic             i_core_clk,
    input wire logic             i_rst_n,
    input wire logic [3:0]       i_frequency_mode_setting,
    input wire logic [1:0]       i_frequency_source_select,
    input wire logic             i_key_enter,
    input wire logic [15:0]      i_count_target,
    // watched outputs
    input wire logic [1:0]       o_ramp_select,
    input mftl_pkg::mftl_speed_t o_speed_select,
    input wire logic [2:0]       o_multi_speed_select,
    input wire logic             o_main_write,
    input wire logic [15:0]      o_count,
    input wire logic             o_count_reached,
    input wire logic [3:0]       o_contact,
    input wire logic [3:0][5:0]  o_output_function
);
    default clocking @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);

    chk_ramp_mode: assert property (
        i_frequency_mode_setting > 4'h2 |=> o_ramp_select == 2'h0) else $error("ramp mode");
    chk_multi_mode: assert property (
        i_frequency_mode_setting != 4'h2 |=> o_multi_speed_select == 3'h0) else $error("multi");
    chk_speed_mode: assert property (
        i_frequency_mode_setting != 4'h1 |=> o_speed_select == mftl_pkg::SPD_MAIN)
        else $error("speed mode");
    chk_count_step: assert property (
        $changed(o_count) |-> o_count == $past(o_count) + 16'h1 || o_count == 16'h0)
        else $error("count step");
    chk_count_sat: assert property (
        o_count == 16'hffff |=> o_count inside {16'hffff, 16'h0}) else $error("count wrap");
    chk_reach_flag: assert property (
        o_count == i_count_target |=> o_count_reached) else $error("reach flag");
    chk_enter_write: assert property (
        i_key_enter && i_frequency_source_select == 2'h0 |=> o_main_write) else $error("write");
    chk_idle_code: assert property (
        $past(o_output_function[3]) == 6'h00 |-> !o_contact[3]) else $error("idle code");

    cov_reached: cover property (o_count_reached);
    cov_write: cover property (o_main_write);
    cov_contact: cover property ($rose(o_contact[3]));
endmodule

bind mftl_terminal_logic mftl_terminal_logic_monitor u_mon (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_frequency_mode_setting(i_frequency_mode_setting),
    .i_frequency_source_select(i_frequency_source_select),
    .i_key_enter(i_key_enter), .i_count_target(i_count_target),
    .o_ramp_select(o_ramp_select), .o_speed_select(o_speed_select),
    .o_multi_speed_select(o_multi_speed_select), .o_main_write(o_main_write),
    .o_count(o_count), .o_count_reached(o_count_reached),
    .o_contact(o_contact), .o_output_function(o_output_function)
);

//--- testbench/tb_multifunction_terminal_logic.sv
`timescale 1ns/10ps
module tb_multifunction_terminal_logic;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] sw = 8'h00;
    logic [7:0] term;
    logic [7:0][5:0] fn = {6'h1b, 6'h1a, 6'h19, 6'h13, 6'h12, 6'h11, 6'h18, 6'h17};
    logic [3:0] mode = 4'h0;
    logic [1:0] src = 2'h1;
    mftl_pkg::mftl_freq_cfg_t cfg = {16'h100, 16'h200, 16'h300, 16'h400, 16'h105, 16'hfe, 16'h101};
    mftl_pkg::mftl_meas_t meas = {16'h5, 16'h6, 16'h5, 16'h6, 16'h3, 16'h2, 16'h4};
    mftl_pkg::mftl_status_t st = '0;
    logic ku = 1'b0;
    logic kd = 1'b0;
    logic ke = 1'b0;
    logic [3:0] fwr = 4'h0;
    logic [5:0] fdat = 6'h00;
    logic [1:0] ramp;
    mftl_pkg::mftl_speed_t spd;
    logic [2:0] multi;
    logic [15:0] cmd;
    logic mw;
    logic [15:0] mwv;
    logic [15:0] cnt;
    logic hit;
    logic [3:0] con;
    logic [3:0][5:0] ofn;
    int failures = 0;
    int tests_run = 0;
    int cyc = 0;
    logic [2:0] sp [6] = '{3'b000, 3'b100, 3'b110, 3'b111, 3'b101, 3'b010};
    logic [1:0] es [6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3, 2'h2};
    int cd [24] = '{1, 2, 4, 8, 9, 10, 11, 12, 13, 14, 15, 18, 19, 20, 30, 31, 32, 27,
                    3, 6, 7, 28, 29, 0};
    int bt [24] = '{18, 16, 15, 14, 13, 12, 11, 10, 9, 8, 7, 6, 5, 4, 2, 1, 0, 3,
                    31, 31, 31, 31, 31, 31};
    logic ex [24] = '{1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 0, 1, 1, 0};

    mftl_switch_bank u_sw (.i_core_clk(clk), .i_close(sw), .o_level(term));
    mftl_terminal_logic #(.UD_FAST_CYC(10), .UD_SLOW_CYC(40), .CNT_MIN_CYC(4)) dut (
        .i_core_clk(clk), .i_rst_n(rst_n), .i_terminal(term), .i_input_function(fn),
        .i_frequency_mode_setting(mode), .i_frequency_source_select(src), .i_freq_cfg(cfg),
        .i_key_up(ku), .i_key_down(kd), .i_key_enter(ke), .i_count_target(16'h2),
        .i_intermediate_count_target(16'h1), .i_output_function_wr(fwr),
        .i_output_function_data(fdat), .i_status(st), .i_meas(meas), .o_ramp_select(ramp),
        .o_speed_select(spd), .o_multi_speed_select(multi), .o_frequency_command(cmd),
        .o_main_write(mw), .o_main_write_value(mwv), .o_count(cnt), .o_count_reached(hit),
        .o_contact(con), .o_output_function(ofn));

    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            end_of_test();
        end
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr_fn(input int k, input logic [5:0] code);
        fwr = 4'h1 << k;
        fdat = code;
        step(1);
        fwr = 4'h0;
        step(1);
    endtask
    task automatic pulse();
        sw[7] = 1'b1;
        step(8);
        sw[7] = 1'b0;
        step(8);
    endtask
    task automatic end_of_test();
        if (failures == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        step(20);
        check("fn_reset", ofn, 24'h002141);
        rst_n = 1'b1;
        for (int r = 0; r < 4; r++) begin
            sw[1:0] = r[1:0];
            step(6);
            check("ramp", ramp, r);
        end
        mode = 4'h3;
        step(2);
        check("ramp_off", ramp, 0);
        sw[1:0] = 2'h0;
        mode = 4'h1;
        for (int i = 0; i < 6; i++) begin
            sw[4:2] = sp[i];
            step(6);
            check("speed", spd, es[i]);
            check("freq", cmd, 16'h100 * (es[i] + 1));
        end
        mode = 4'h2;
        fn[4:2] = {6'h16, 6'h15, 6'h14};
        sw[4:2] = 3'b101;
        step(6);
        check("speed_off", spd, 0);
        check("multi", multi, 3'b101);
        mode = 4'h1;
        step(2);
        check("multi_off", multi, 0);
        sw[4:2] = 3'b000;
        mode = 4'h0;
        src = 2'h0;
        step(3);
        sw[5] = 1'b1;
        step(7);
        check("up_first", cmd, 16'h101);
        step(10);
        check("up_fast", cmd, 16'h102);
        step(60);
        check("up_max", cmd, 16'h105);
        sw[6] = 1'b1;
        step(30);
        check("both", cmd, 16'h105);
        sw[5] = 1'b0;
        step(60);
        check("down_min", cmd, 16'h101);
        sw[6] = 1'b0;
        src = 2'h1;
        sw[5] = 1'b1;
        step(30);
        check("up_off", cmd, 16'h100);
        sw[5] = 1'b0;
        step(3);
        src = 2'h0;
        step(3);
        ku = 1'b1;
        step(1);
        ku = 1'b0;
        step(3);
        check("key_wait", cmd, 16'h100);
        ke = 1'b1;
        step(1);
        ke = 1'b0;
        check("write", {mw, mwv}, 17'h10101);
        step(3);
        check("write_cmd", {mw, cmd}, 17'h00101);
        kd = 1'b1;
        step(1);
        kd = 1'b0;
        ke = 1'b1;
        step(1);
        ke = 1'b0;
        check("key_down", {mw, mwv}, 17'h10101);
        wr_fn(0, 6'h10);
        wr_fn(1, 6'h11);
        wr_fn(2, 6'h21);
        step(2);
        check("fn_wr", ofn, 24'h002450);
        pulse();
        check("cnt1", {cnt, con[1:0]}, 18'h00006);
        pulse();
        check("cnt2", {cnt, hit, con[1:0]}, 19'h00017);
        pulse();
        check("cnt_hold", cnt, 16'h2);
        fn[6] = 6'h1c;
        sw[6] = 1'b1;
        step(8);
        check("cnt_clr", cnt, 16'h0);
        sw[6] = 1'b0;
        step(4);
        pulse();
        check("cnt_again", cnt, 16'h1);
        for (int i = 0; i < 24; i++) begin
            wr_fn(3, cd[i][5:0]);
            st = (bt[i] < 19) ? 19'h1 << bt[i] : 19'h0;
            step(3);
            check("contact", con[3], ex[i]);
            st = '0;
            step(3);
            check("contact_off", con[3], (bt[i] < 19) ? 1'b0 : ex[i]);
        end
        end_of_test();
    end
endmodule
